/* File: logic/sbl_master.sv */
// permanent bus master end: address drive and byte-lane steering
`timescale 1ns/100ps
// Notes on behaviour
// - LA[23:17] picks a 128KB block of 16MB
// - adapter sizes memory from LA lines only
// - master drives LA tri-state, releases for alternate
// - LA meaningless during I/O accesses
// - SA addresses 1MB; SA[9:0] is I/O
// - upper byte enable low for upper-lane bytes
// - upper byte enable driven tri-state
// - 8-bit boards use only the low lane
// - enable low, A0 low: word transfer
// - enable low, A0 high: odd byte upper
// - enable high, A0 low: even byte low
// - enable high, A0 high: odd byte low
// - address captured on latch enable fall
`include "sbl_consts.svh"
module sbl_master (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqMem,
  input wire logic reqWrite,
  input wire logic reqWide,
  input wire logic [23:0] reqAddr,
  input wire sbl_pkg::sbl_data_t reqWdata,
  // user answer
  output logic rspValid,
  output sbl_pkg::sbl_data_t rspRdata,
  output logic rspMem16,
  // bus
  sbl_bus_if.master bus
);
  import sbl_pkg::*;

  typedef enum {ST_IDLE, ST_ALE, ST_CMD, ST_DONE, ST_FLOAT} sbl_mst_e;

  ////////////////////////////////////////////////////////////////
  // lane decode: upper enable and address bit 0 pick the lane use
  function automatic sbl_lane_e laneOf(input logic enN, input logic bit0);
    sbl_lane_e sel;
    case ({enN, bit0})
      2'h0: sel = SBL_WORD;
      2'h1: sel = SBL_ODD_HI;
      2'h2: sel = SBL_EVEN_LO;
      default: sel = SBL_ODD_LO;
    endcase
    return sel;
  endfunction : laneOf

  ////////////////////////////////////////////////////////////////
  // synchronisers for pins from the far side
  logic [1:0] altSync_r;
  logic [1:0] cs16Sync_r;
  sbl_data_t rdSync1_r;
  sbl_data_t rdSync2_r;
  always_ff @(posedge clk)
  begin
    altSync_r <= {altSync_r[0], bus.altMasterN};
    cs16Sync_r <= {cs16Sync_r[0], bus.mem16CsN};
    rdSync1_r <= bus.devDataOut;
    rdSync2_r <= rdSync1_r;
  end
  wire altActive = ~altSync_r[1];

  ////////////////////////////////////////////////////////////////
  // lane selection from width and address bit 0
  wire a0 = reqAddr[0];
  // 8-bit transfers never assert the upper enable, so their odd bytes go low
  wire hiEnN = ~reqWide;
  sbl_lane_e lane;
  assign lane = laneOf(hiEnN, a0);
  wire wordCyc = (lane == SBL_WORD);
  wire oddHiCyc = (lane == SBL_ODD_HI);
  // byte cycles mirror the byte onto both lanes so 8-bit boards see it
  wire [15:0] wdata = wordCyc ? reqWdata : {reqWdata[7:0], reqWdata[7:0]};
  // the low lane always carries something; the upper one only with the enable
  wire [1:0] laneOe = {wordCyc | oddHiCyc, 1'b1};

  ////////////////////////////////////////////////////////////////
  // transfer sequencer
  // a far-side board passes every pin through two flip-flops, so the strobe
  // stays low long enough for its size report and read data to come back
  sbl_mst_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic memCyc_r, wrCyc_r;
  logic [1:0] lane_r;
  wire cntDone = (cnt_r == 4'h0);
  wire inIdle = (state_r == ST_IDLE);
  wire inCmd = (state_r == ST_CMD);
  wire taking = inIdle && !altActive && reqValid;
  wire cmdLast = inCmd && cntDone;
  wire doneLast = (state_r == ST_DONE) && cntDone;
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (altActive)
          state_nxt = ST_FLOAT;
        else if (reqValid)
          state_nxt = ST_ALE;
      ST_ALE:
        state_nxt = ST_CMD;
      ST_CMD:
        if (cntDone)
          state_nxt = ST_DONE;
      // address and data stay put until the far side has taken a write
      ST_DONE:
        if (cntDone)
          state_nxt = ST_IDLE;
      // resume only once the alternate master lets go
      ST_FLOAT:
        if (!altActive)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end
  assign reqReady = inIdle && !altActive;

  // one counter times both the strobe and the recovery after it
  always_comb
  begin
    cnt_nxt = cntDone ? 4'h0 : cnt_r - 4'h1;
    if (state_r == ST_ALE)
      cnt_nxt = 4'(`SBL_CMD_CYCLES - 1);
    else if (cmdLast)
      cnt_nxt = 4'(`SBL_RECOVER_CYCLES - 1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // request capture: fields are held on the pins until the next request
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bus.laOut <= 7'h00;
      bus.saOut <= 20'h00000;
      bus.byteHighEnOutN <= 1'b1;
      bus.dataOut <= 16'h0000;
      memCyc_r <= 1'b0;
      wrCyc_r <= 1'b0;
      lane_r <= 2'h0;
    end
    else if (taking)
    begin
      // I/O cycles carry only ten address bits; LA left as zero
      bus.laOut <= reqMem ? reqAddr[`SBL_LA_MSB:`SBL_LA_LSB] : 7'h00;
      bus.saOut <= reqMem ? reqAddr[`SBL_SA_MSB:0] :
                   {10'h000, reqAddr[`SBL_IO_MSB:0]};
      bus.byteHighEnOutN <= hiEnN;
      bus.dataOut <= wdata;
      memCyc_r <= reqMem;
      wrCyc_r <= reqWrite;
      lane_r <= laneOe;
    end
  end

  ////////////////////////////////////////////////////////////////
  // answer capture
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rspValid <= 1'b0;
      rspRdata <= 16'h0000;
      rspMem16 <= 1'b0;
    end
    else
    begin
      rspValid <= doneLast;
      // taken at the close of the strobe, once both pipelines have filled
      if (cmdLast)
      begin
        rspMem16 <= memCyc_r & ~cs16Sync_r[1];
        rspRdata <= rdSync2_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drive; address, byte enable and data drivers float while the alternate owns the bus; strobes and latch enable stay driven
  wire owning = (state_r != ST_FLOAT) && !altActive;
  assign bus.laOe = owning;
  assign bus.saOe = owning;
  assign bus.byteHighEnOe = owning;
  // held high for the whole alternate cycle
  assign bus.addrLatchEn = (state_r == ST_ALE) || !owning;
  assign bus.memStrobeN = ~(inCmd & memCyc_r);
  assign bus.ioStrobeN = ~(inCmd & ~memCyc_r);
  assign bus.writeDir = wrCyc_r;
  // write data goes out only on the lanes that the cycle uses
  wire dataDrive = owning && wrCyc_r && !inIdle;
  wire [1:0] laneDrive;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_laneDrive
      assign laneDrive[g] = dataDrive & lane_r[g];
    end
  endgenerate
  assign bus.dataOe = laneDrive;
endmodule : sbl_master

/* File: shared/sbl_consts.svh */
// timing and field constants for the stack bus address and byte-lane block
`ifndef SBL_CONSTS_SVH
`define SBL_CONSTS_SVH
`define SBL_LA_MSB 23
`define SBL_LA_LSB 17
`define SBL_SA_MSB 19
`define SBL_IO_MSB 9
`define SBL_LANE_W 8
`define SBL_IO_ADDR_W 10
`define SBL_LA_W 7
`define SBL_SA_W 20
`define SBL_DATA_W 16
`define SBL_CMD_CYCLES 8
`define SBL_RECOVER_CYCLES 3
`endif

/* File: shared/sbl_pkg.sv */
// types shared by both ends of the stack bus address and byte-lane block
package sbl_pkg;
  typedef logic [6:0] sbl_la_t;
  typedef logic [19:0] sbl_sa_t;
  typedef logic [15:0] sbl_data_t;
  typedef logic [7:0] sbl_byte_t;
  typedef enum logic [1:0] {SBL_WORD, SBL_ODD_HI, SBL_EVEN_LO, SBL_ODD_LO} sbl_lane_e;
endpackage : sbl_pkg

/* File: shared/sbl_bus_if.sv */
// stack bus wires between the permanent master and an adapter board
`timescale 1ns/100ps
interface sbl_bus_if;
  import sbl_pkg::*;
  sbl_la_t laOut;
  logic laOe;
  sbl_sa_t saOut;
  logic saOe;
  logic byteHighEnOutN;
  logic byteHighEnOe;
  logic addrLatchEn;
  logic memStrobeN;
  logic ioStrobeN;
  logic writeDir;
  sbl_data_t dataOut;
  logic [1:0] dataOe;
  sbl_data_t devDataOut;
  logic [1:0] devDataOe;
  logic mem16CsN;
  logic altMasterN;
  modport master (
    output laOut, laOe, saOut, saOe, byteHighEnOutN, byteHighEnOe, addrLatchEn,
    output memStrobeN, ioStrobeN, writeDir, dataOut, dataOe,
    input devDataOut, devDataOe, mem16CsN, altMasterN
  );
  modport adapter (
    input laOut, laOe, saOut, saOe, byteHighEnOutN, byteHighEnOe, addrLatchEn,
    input memStrobeN, ioStrobeN, writeDir, dataOut, dataOe,
    output devDataOut, devDataOe, mem16CsN
  );
endinterface : sbl_bus_if

/* File: logic/sbl_adapter.sv */
// adapter board end: address latch, size report and byte-lane response
`timescale 1ns/100ps
`include "sbl_consts.svh"
module sbl_adapter (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // board configuration
  input wire logic boardWide,
  input wire sbl_pkg::sbl_la_t memBlock,
  input wire logic [9:0] ioBase,
  // user side
  input wire sbl_pkg::sbl_data_t readData,
  output logic wrValid,
  output logic [23:0] wrAddr,
  output sbl_pkg::sbl_data_t wrData,
  output logic [1:0] wrLanes,
  // bus
  sbl_bus_if.adapter bus
);
  import sbl_pkg::*;

  ////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] aleSync_r, memSync_r, ioSync_r, wrSync_r, hiSync_r;
  sbl_la_t la1_r, la2_r;
  sbl_sa_t sa1_r, sa2_r;
  sbl_data_t d1_r, d2_r;
  always_ff @(posedge clk)
  begin
    aleSync_r <= {aleSync_r[0], bus.addrLatchEn};
    memSync_r <= {memSync_r[0], bus.memStrobeN};
    ioSync_r <= {ioSync_r[0], bus.ioStrobeN};
    wrSync_r <= {wrSync_r[0], bus.writeDir};
    hiSync_r <= {hiSync_r[0], bus.byteHighEnOutN};
    la1_r <= bus.laOut;
    la2_r <= la1_r;
    sa1_r <= bus.saOut;
    sa2_r <= sa1_r;
    d1_r <= bus.dataOut;
    d2_r <= d1_r;
  end

  ////////////////////////////////////////////////////////////////
  // address latch on falling latch enable
  logic aleOld_r;
  sbl_la_t laLat_r;
  sbl_sa_t saLat_r;
  logic hiLat_r;
  logic memOld_r, ioOld_r;
  wire aleFall = aleOld_r & ~aleSync_r[1];
  wire memHit = (la2_r == memBlock);
  wire ioHit = (saLat_r[`SBL_IO_MSB:0] == ioBase);
  wire memAct = ~memSync_r[1] & memHit;
  wire ioAct = ~ioSync_r[1] & ioHit;
  wire cycAct = memAct | ioAct;
  wire a0 = saLat_r[0];
  // narrow boards answer only on the low lane
  wire useHi = boardWide & ~hiLat_r;
  wire [1:0] lanes = useHi ? (a0 ? 2'h2 : 2'h3) : 2'h1;
  wire [7:0] oddByte = (useHi && a0) ? d2_r[15:8] : d2_r[7:0];
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aleOld_r <= 1'b0;
      laLat_r <= 7'h00;
      saLat_r <= 20'h00000;
      hiLat_r <= 1'b1;
      memOld_r <= 1'b1;
      ioOld_r <= 1'b1;
      wrValid <= 1'b0;
      wrAddr <= 24'h000000;
      wrData <= 16'h0000;
      wrLanes <= 2'h0;
      bus.devDataOut <= 16'h0000;
    end
    else
    begin
      aleOld_r <= aleSync_r[1];
      memOld_r <= memSync_r[1];
      ioOld_r <= ioSync_r[1];
      wrValid <= 1'b0;
      if (aleFall)
      begin
        laLat_r <= la2_r;
        saLat_r <= sa2_r;
        hiLat_r <= hiSync_r[1];
      end
      // write taken as the strobe rises, when the data has settled
      if (((memSync_r[1] & ~memOld_r & memHit) | (ioSync_r[1] & ~ioOld_r & ioHit))
          && wrSync_r[1])
      begin
        wrValid <= 1'b1;
        wrAddr <= {laLat_r, saLat_r[16:0]};
        wrData <= (lanes == 2'h3) ? d2_r : {8'h00, (a0 ? oddByte : d2_r[7:0])};
        wrLanes <= lanes;
      end
      bus.devDataOut <= (lanes == 2'h3) ? readData :
                        {readData[7:0], readData[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // responses
  assign bus.mem16CsN = ~(boardWide & memHit);
  assign bus.devDataOe = (cycAct && !wrSync_r[1]) ? lanes : 2'h0;
endmodule : sbl_adapter

/* File: sim/sbl_check_sva.sv */
// stack bus checker: lane, drive and cycle relations on the shared wires
`timescale 1ns/100ps
module sbl_check_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus wires
  input wire sbl_pkg::sbl_la_t laOut,
  input wire logic laOe,
  input wire sbl_pkg::sbl_sa_t saOut,
  input wire logic byteHighEnOutN,
  input wire logic byteHighEnOe,
  input wire logic addrLatchEn,
  input wire logic memStrobeN,
  input wire logic ioStrobeN,
  input wire logic [1:0] dataOe,
  input wire logic altMasterN
);
  import sbl_pkg::*;
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  wire strobe = !memStrobeN || !ioStrobeN;
  wire wrLive = dataOe != 2'h0 && byteHighEnOe;
  ////////////////////////////////////////
  // address must hold still while a strobe is low
  sequence s_cmd;
    strobe && $stable(saOut) && $stable(laOut);
  endsequence
  property p_cycle;
    $rose(addrLatchEn) && altMasterN |=> s_cmd [*8] ##1 !strobe;
  endproperty
  a_cycle: assert property (p_cycle) else $error("bus cycle shape wrong");
  property p_laIo;
    !ioStrobeN |-> laOut == 7'h00;
  endproperty
  a_laIo: assert property (p_laIo) else $error("upper address set on io");
  property p_float;
    !altMasterN [*4] |-> !laOe && !byteHighEnOe && dataOe == 2'h0;
  endproperty
  a_float: assert property (p_float) else $error("master drives under alternate");
  property p_aleHeld;
    !altMasterN [*4] |-> addrLatchEn;
  endproperty
  a_aleHeld: assert property (p_aleHeld) else $error("latch enable not held");
  property p_resume;
    $rose(altMasterN) |-> (!laOe && !byteHighEnOe) [*2];
  endproperty
  a_resume: assert property (p_resume) else $error("master resumed too early");
  property p_word;
    wrLive && !byteHighEnOutN && !saOut[0] |-> dataOe == 2'h3;
  endproperty
  a_word: assert property (p_word) else $error("word cycle lanes wrong");
  property p_oddHi;
    wrLive && !byteHighEnOutN && saOut[0] |-> dataOe[1];
  endproperty
  a_oddHi: assert property (p_oddHi) else $error("upper lane not driven");
  property p_narrow;
    wrLive && byteHighEnOutN |-> dataOe[0];
  endproperty
  a_narrow: assert property (p_narrow) else $error("low lane not driven");
endmodule : sbl_check_sva

/* File: sim/test_stack_bus_address_byte_lanes.sv */
// self-checking bench: master and adapter joined over the stack bus
`timescale 1ns/100ps
module test_stack_bus_address_byte_lanes;
  import sbl_pkg::*;
  logic clk, reset, reqValid, reqReady, reqMem, reqWrite, reqWide, rspValid, rspMem16, wrValid;
  logic [23:0] reqAddr, wrAddr;
  sbl_data_t reqWdata, rspRdata, readData, wrData;
  logic [1:0] wrLanes;
  int num_errors, compares, cyc, nWr, k;
  // write table: hits with every lane case, last one on io
  logic [4:0] wMem = 5'h0f;
  logic [4:0] wWide = 5'h09;
  logic [23:0] wAddr [5] = '{24'h0a1234, 24'h0a1235, 24'h0a1236, 24'h0a1237, 24'h000300};
  sbl_data_t wDat [5] = '{16'hbeef, 16'h00a5, 16'h005a, 16'h3c3c, 16'h0077};
  sbl_data_t wMsk [5] = '{16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
  logic [1:0] wLn [5] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h1};
  sbl_bus_if bus ();
  sbl_master i_sbl_master (.clk(clk), .reset(reset), .reqValid(reqValid), .reqReady(reqReady),
    .reqMem(reqMem), .reqWrite(reqWrite), .reqWide(reqWide), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata), .rspMem16(rspMem16),
    .bus(bus));
  sbl_adapter i_sbl_adapter (.clk(clk), .reset(reset), .boardWide(1'b1), .memBlock(7'h05),
    .ioBase(10'h300), .readData(readData), .wrValid(wrValid), .wrAddr(wrAddr),
    .wrData(wrData), .wrLanes(wrLanes), .bus(bus));
  sbl_check_sva i_sbl_check_sva (.clk(clk), .reset(reset), .laOut(bus.laOut), .laOe(bus.laOe),
    .saOut(bus.saOut), .byteHighEnOutN(bus.byteHighEnOutN), .byteHighEnOe(bus.byteHighEnOe),
    .addrLatchEn(bus.addrLatchEn), .memStrobeN(bus.memStrobeN), .ioStrobeN(bus.ioStrobeN),
    .dataOe(bus.dataOe), .altMasterN(bus.altMasterN));
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    nWr <= nWr + int'(wrValid === 1'b1);
    if (cyc == 2000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one user request, held until taken, then wait for the answer pulse
  task automatic req(input logic mem, wr, wide, input logic [23:0] a, input sbl_data_t d);
    @(negedge clk);
    {reqMem, reqWrite, reqWide, reqAddr, reqWdata, reqValid} = {mem, wr, wide, a, d, 1'b1};
    for (k = 0; k < 20 && reqReady !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    for (k = 0; k < 40 && rspValid !== 1'b1; k++) @(negedge clk);
    chk("rspValid", rspValid, 1'b1);
  endtask : req
  task automatic summarize();
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  initial
  begin
    {reqValid, reqMem, reqWrite, reqWide, reqAddr, reqWdata} = '0;
    readData = 16'hc3a1;
    bus.altMasterN = 1'b1;
    reset = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      req(wMem[i], 1'b1, wWide[i], wAddr[i], wDat[i]);
      chk("rspMem16", rspMem16, wMem[i]);
      for (k = 0; k < 12 && wrValid !== 1'b1; k++) @(negedge clk);
      chk("wrLanes", wrLanes, wLn[i]);
      chk("wrAddr", wrAddr, wAddr[i]);
      chk("wrData", wrData & wMsk[i], wDat[i] & wMsk[i]);
    end
    req(1'b1, 1'b0, 1'b1, 24'h0a1000, 16'h0000);
    chk("rspRdata", rspRdata, 16'hc3a1);
    req(1'b1, 1'b1, 1'b1, 24'h100000, 16'h1111);
    chk("rspMem16", rspMem16, 1'b0);
    // a miss and a read must leave the write count alone
    repeat (8) @(negedge clk);
    chk("nWr", nWr, 24'd5);
    bus.altMasterN = 1'b0;
    repeat (6) @(negedge clk);
    chk("reqReady", reqReady, 1'b0);
    chk("drives", {bus.laOe, bus.saOe, bus.byteHighEnOe, bus.dataOe, bus.devDataOe}, 24'h0);
    chk("addrLatchEn", bus.addrLatchEn, 1'b1);
    bus.altMasterN = 1'b1;
    req(1'b1, 1'b1, 1'b1, 24'h0a2000, 16'h1234);
    chk("rspMem16", rspMem16, 1'b1);
    summarize();
  end
endmodule : test_stack_bus_address_byte_lanes
